// File: design/scd_cmd_decoder.sv
// Purpose: decodes 16-bit serial command frames into three register sets
// Assumes: chip select and frame data settle before the core samples them
// Notes: executes a few core clocks after chip select rises
`timescale 1ns/10ps
`default_nettype none
module scd_cmd_decoder (
  // core clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  // serial link
  input  wire logic                 spi_clk,
  input  wire logic                 chip_select_low,
  input  wire logic                 spi_data_in,
  output logic                      spi_data_out,
  output logic                      spi_data_oe,
  // functional blocks
  input  wire scd_pkg::scd_reg_set_t status_fault_set,
  output scd_pkg::scd_reg_set_t     config_regs,
  output scd_pkg::scd_reg_set_t     control_regs,
  output scd_pkg::scd_reg_set_t     status_regs,
  output logic                      self_test_write_unlock
);
  import scd_pkg::*;
  `include "scd_defs.svh"

  scd_link_if   lnk ();
  scd_core_st_t cur;
  scd_core_st_t next_cur;
  logic         cs_s;
  logic         seq_s;
  scd_cmd_t     ex_cmd;
  logic [3:0]   ex_addr;
  logic [7:0]   ex_data;
  logic         cnt_ok;
  logic         cmd_ok;
  logic         addr_ok;
  logic         ex_ok;
  logic         exec;
  logic         unlock;
  scd_reg_set_t sts_hw;
  logic [15:0]  cfg_valid;
  logic [15:0]  sts_valid;
  logic [15:0]  ctl_valid;

  scd_shift u_shift (
    .spi_clk         (spi_clk),
    .rst_b           (rst_b),
    .chip_select_low (chip_select_low),
    .spi_data_in     (spi_data_in),
    .spi_data_out    (spi_data_out),
    .lnk             (lnk.link)
  );

  // frame sequence toggle lets a frame with no clocks be told from a repeat
  scd_sync2 #(.W(2), .INIT(2'b01)) u_sync (
    .clock (clock),
    .rst_b (rst_b),
    .d     ({lnk.rx_seq, chip_select_low}),
    .q     ({seq_s, cs_s})
  );

  assign cfg_valid = `SCD_CFG_VALID;
  assign sts_valid = `SCD_STS_VALID;
  assign ctl_valid = `SCD_CTL_VALID;

  assign exec    = (cur.st == SCD_EXEC);
  assign ex_cmd  = scd_cmd_t'(lnk.rx_word[`SCD_CMD_HI:`SCD_CMD_LO]);
  assign ex_addr = lnk.rx_word[`SCD_ADR_HI:`SCD_ADR_LO];
  assign ex_data = lnk.rx_word[`SCD_DAT_HI:0];
  assign unlock  = cur.ctl[`SCD_UNLOCK_REG][`SCD_UNLOCK_BIT];
  assign cnt_ok  = (lnk.bit_cnt == `SCD_FRAME_BITS) && (seq_s != cur.seq_seen);
  assign cmd_ok  = (ex_cmd != SCD_CMD_RESP) && !lnk.rx_word[`SCD_CMD_HI];

  always_comb begin
    case (ex_cmd)
      SCD_CMD_RD_CFG, SCD_CMD_WR_CFG: addr_ok = cfg_valid[ex_addr];
      SCD_CMD_RD_STS, SCD_CMD_WR_STS: addr_ok = sts_valid[ex_addr];
      SCD_CMD_RD_CTL, SCD_CMD_WR_CTL: addr_ok = ctl_valid[ex_addr];
      default:                        addr_ok = 1'b1;
    endcase
  end

  assign ex_ok = cnt_ok && cmd_ok && addr_ok;

  // fault inputs are frozen while the self test unlock is set
  for (genvar i = 0; i < 16; i++) begin : g_sts
    assign sts_hw[i] = unlock ? cur.sts[i] : (cur.sts[i] | status_fault_set[i]);
  end

  always_comb begin
    next_cur     = cur;
    next_cur.oe  = ~cs_s;
    next_cur.sts = sts_hw;
    case (cur.st)
      SCD_IDLE: begin
        if (!cs_s) begin
          next_cur.st = SCD_FRAME;
        end
      end
      SCD_FRAME: begin
        if (cs_s) begin
          next_cur.st = SCD_EXEC;
        end
      end
      SCD_EXEC: begin
        next_cur.st       = SCD_IDLE;
        next_cur.seq_seen = seq_s;
        next_cur.resp     = `SCD_NO_RESP;
        if (!ex_ok) begin
          next_cur.sts[`SCD_FAULT_REG][`SCD_COMM_ERR_BIT] = 1'b1;
        end else begin
          case (ex_cmd)
            SCD_CMD_CHECK: begin
              next_cur.resp = {SCD_CMD_RESP, lnk.rx_word[`SCD_ADR_HI:0]};
            end
            SCD_CMD_RD_CFG: begin
              next_cur.resp = {ex_cmd, ex_addr, cur.cfg[ex_addr]};
            end
            SCD_CMD_WR_CFG: begin
              next_cur.cfg[ex_addr] = ex_data;
            end
            SCD_CMD_RD_STS: begin
              next_cur.resp = {ex_cmd, ex_addr, cur.sts[ex_addr]};
            end
            SCD_CMD_WR_STS: begin
              if (unlock) begin
                next_cur.sts[ex_addr] = ex_data;
              end else begin
                // a fault arriving with the clear still lands
                next_cur.sts[ex_addr] = (cur.sts[ex_addr] & ex_data)
                                        | status_fault_set[ex_addr];
              end
            end
            SCD_CMD_RD_CTL: begin
              next_cur.resp = {ex_cmd, ex_addr, cur.ctl[ex_addr]};
            end
            SCD_CMD_WR_CTL: begin
              next_cur.ctl[ex_addr] = ex_data;
            end
            default: begin
              next_cur.resp = `SCD_NO_RESP;
            end
          endcase
        end
      end
      default: begin
        next_cur.st = SCD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cur.st       <= SCD_IDLE;
      cur.seq_seen <= 1'b0;
      cur.oe       <= 1'b0;
      cur.resp     <= `SCD_NO_RESP;
      cur.cfg      <= `SCD_CFG_RESET;
      cur.ctl      <= `SCD_CTL_RESET;
      cur.sts      <= `SCD_STS_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign lnk.resp_word          = cur.resp;
  assign spi_data_oe            = cur.oe;
  assign config_regs            = cur.cfg;
  assign control_regs           = cur.ctl;
  assign status_regs            = cur.sts;
  assign self_test_write_unlock = unlock;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  cfg_exec_only_a: assert property (
    $changed(cur.cfg) |-> $past(cur.st) == SCD_EXEC)
    else $error("configuration changed outside execution");

  check_echo_a: assert property (
    exec && ex_ok && ex_cmd == SCD_CMD_CHECK
    |=> cur.resp == {SCD_CMD_RESP, $past(lnk.rx_word[`SCD_ADR_HI:0])})
    else $error("link check answer wrong");

  cfg_write_a: assert property (
    exec && ex_ok && ex_cmd == SCD_CMD_WR_CFG
    |=> cur.cfg[$past(ex_addr)] == $past(ex_data))
    else $error("configuration write lost");

  ctl_write_a: assert property (
    exec && ex_ok && ex_cmd == SCD_CMD_WR_CTL
    |=> cur.ctl[$past(ex_addr)] == $past(ex_data))
    else $error("control write lost");

  sts_clear_only_a: assert property (
    exec && ex_ok && ex_cmd == SCD_CMD_WR_STS && !unlock
    |=> (cur.sts[$past(ex_addr)] & ~$past(cur.sts[ex_addr])
         & ~$past(status_fault_set[ex_addr])) == 8'h00)
    else $error("status write set a bit while locked");

  short_frame_a: assert property (
    exec && lnk.bit_cnt != `SCD_FRAME_BITS
    |=> cur.sts[`SCD_FAULT_REG][`SCD_COMM_ERR_BIT] && $stable(cur.cfg) && $stable(cur.ctl))
    else $error("bad frame length not flagged or not ignored");

  bad_cmd_a: assert property (
    exec && lnk.rx_word[`SCD_CMD_HI]
    |=> cur.sts[`SCD_FAULT_REG][`SCD_COMM_ERR_BIT] && cur.resp == `SCD_NO_RESP)
    else $error("invalid command not flagged");

  sts_read_a: assert property (
    exec && ex_ok && ex_cmd == SCD_CMD_RD_STS
    |=> cur.resp[`SCD_DAT_HI:0] == $past(cur.sts[ex_addr]) && cur.resp[15:12] == 4'h3)
    else $error("status read answer wrong");

  reset_vals_a: assert property (
    $rose(rst_b) |-> cur.cfg == `SCD_CFG_RESET && cur.sts == `SCD_STS_RESET)
    else $error("register defaults missing after reset");

  frame_exec_a: assert property (
    cur.st == SCD_FRAME && cs_s |=> exec ##1 cur.st == SCD_IDLE)
    else $error("deselect did not execute once");

  cfg_read_a: assert property (
    exec && ex_ok && ex_cmd == SCD_CMD_RD_CFG
    |=> cur.resp[`SCD_DAT_HI:0] == $past(cur.cfg[ex_addr]) && cur.resp[15:12] == 4'h1)
    else $error("configuration read answer wrong");

  ctl_read_a: assert property (
    exec && ex_ok && ex_cmd == SCD_CMD_RD_CTL
    |=> cur.resp[`SCD_DAT_HI:0] == $past(cur.ctl[ex_addr]) && cur.resp[15:12] == 4'h5)
    else $error("control read answer wrong");

  write_no_answer_a: assert property (
    exec && (ex_cmd == SCD_CMD_WR_CFG || ex_cmd == SCD_CMD_WR_CTL || ex_cmd == SCD_CMD_WR_STS)
    |=> cur.resp == `SCD_NO_RESP)
    else $error("write left a non-empty answer");

  bad_addr_a: assert property (
    exec && ex_cmd == SCD_CMD_WR_CFG && !cfg_valid[ex_addr]
    |=> cur.sts[`SCD_FAULT_REG][`SCD_COMM_ERR_BIT] && $stable(cur.cfg))
    else $error("invalid address not flagged or not ignored");

  unlock_freeze_a: assert property (
    unlock && !exec |=> $stable(cur.sts))
    else $error("status moved while self test unlock set");

  err_clear_a: assert property (
    $fell(cur.sts[`SCD_FAULT_REG][`SCD_COMM_ERR_BIT])
    |-> $past(exec && ex_ok && ex_cmd == SCD_CMD_WR_STS))
    else $error("link error bit cleared without a status write");

  oe_off_a: assert property (
    cs_s |=> !cur.oe)
    else $error("out driver enabled while deselected");

  cover_read_c:   cover property (exec && ex_ok && ex_cmd == SCD_CMD_RD_STS);
  cover_check_c:  cover property (exec && ex_ok && ex_cmd == SCD_CMD_CHECK);
  cover_unlock_c: cover property (exec && ex_ok && ex_cmd == SCD_CMD_WR_STS && unlock);
  cover_error_c:  cover property (exec && !cnt_ok);
endmodule
`default_nettype wire

// File: pkg/scd_defs.svh
// Purpose: constants of the serial command decoder: field positions, offsets, reset values
// Assumes: included by the bench and by every design file that needs a constant
// Notes: register sets are sixteen 8-bit entries indexed by the address nibble
// Function
// - a frame is 16 bits, top 4 the command code, low 12 the payload
// - each parameter lives in an 8-bit register, address nibble selects, low byte is data
// - writes take effect with their own frame; read data returns in the next frame
// - no handshake is needed, but chip select must stay high a few core clocks between frames
// - a command executes only at the rising edge of chip select
// - code 0 is a link check, answered with code 7 and the payload echoed
// - code 1 reads and code 2 writes the addressed configuration register
// - code 3 reads and code 4 writes the addressed status register
// - code 5 reads and code 6 writes the addressed control register
// - configuration registers hold the options of each functional block
// - control registers switch outputs and hold pwm duty values
// - status registers report faults and conditions from the functional blocks
// - bit 3 of the supply and system fault status register flags a link error
// - reset loads every register default; the supply fault status register clears to zero
// - a frame without exactly 16 clocks is ignored and flags the link error
// - an invalid command code or register address also flags the link error
// - msb first; input sampled on rising clock edge, output changes on falling edge
// - status writes only clear bits unless self test unlock is set, which also freezes faults
`ifndef SCD_DEFS_SVH
`define SCD_DEFS_SVH

`define SCD_FRAME_BITS   5'd16
`define SCD_CNT_SAT      5'd17
`define SCD_CMD_HI       15
`define SCD_CMD_LO       12
`define SCD_ADR_HI       11
`define SCD_ADR_LO       8
`define SCD_DAT_HI       7
`define SCD_FAULT_REG    4'hd
`define SCD_COMM_ERR_BIT 3
`define SCD_UNLOCK_REG   4'hf
`define SCD_UNLOCK_BIT   7
`define SCD_NO_RESP      16'h0000
`define SCD_CFG_RESET    128'h00000021_53ca0080_10001801_10100010
`define SCD_CTL_RESET    128'h00000000_00000000_00000000_00000000
`define SCD_STS_RESET    128'h00000000_00000000_00000000_00000000
`define SCD_CFG_VALID    16'hfdfd
`define SCD_STS_VALID    16'hffff
`define SCD_CTL_VALID    16'hffff

`endif

// File: pkg/scd_pkg.sv
// Purpose: types shared by the serial command decoder modules
// Assumes: scd_defs.svh on the include path
// Notes: command codes are the wire encoding of the top nibble
package scd_pkg;
  typedef enum logic [3:0] {
    SCD_CMD_CHECK  = 4'h0,
    SCD_CMD_RD_CFG = 4'h1,
    SCD_CMD_WR_CFG = 4'h2,
    SCD_CMD_RD_STS = 4'h3,
    SCD_CMD_WR_STS = 4'h4,
    SCD_CMD_RD_CTL = 4'h5,
    SCD_CMD_WR_CTL = 4'h6,
    SCD_CMD_RESP   = 4'h7
  } scd_cmd_t;

  typedef enum logic [1:0] {SCD_IDLE, SCD_FRAME, SCD_EXEC} scd_state_t;

  typedef logic [15:0][7:0] scd_reg_set_t;

  typedef struct packed {
    scd_state_t   st;
    logic         seq_seen;
    logic         oe;
    logic [15:0]  resp;
    scd_reg_set_t cfg;
    scd_reg_set_t ctl;
    scd_reg_set_t sts;
  } scd_core_st_t;
endpackage

// File: pkg/scd_link_if.sv
// Purpose: carrier between the link-clock shifter and the core
// Assumes: link side driven on spi_clk, core side on clock
// Notes: words are quasi-static; the core reads them only after chip select settles high
`timescale 1ns/10ps
`default_nettype none
interface scd_link_if;
  logic [15:0] rx_word;
  logic [4:0]  bit_cnt;
  logic        rx_seq;
  logic [15:0] resp_word;
  modport link (output rx_word, output bit_cnt, output rx_seq, input resp_word);
  modport core (input rx_word, input bit_cnt, input rx_seq, output resp_word);
endinterface
`default_nettype wire

// File: design/scd_sync2.sv
// Purpose: two flip-flop level synchroniser into the core clock
// Assumes: synchronous active-low reset
// Notes: the first stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module scd_sync2 #(
  parameter int unsigned W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // core clock
  input  wire logic         clock,
  input  wire logic         rst_b,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } scd_sync_st_t;

  scd_sync_st_t cur;
  scd_sync_st_t next_cur;

  always_comb begin
    next_cur.s1 = d;
    next_cur.s2 = cur.s1;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cur <= {INIT, INIT};
    end else begin
      cur <= next_cur;
    end
  end

  assign q = cur.s2;
endmodule
`default_nettype wire

// File: design/scd_shift.sv
// Purpose: serial shifter running on the host's serial clock
// Assumes: serial clock low whenever chip select moves
// Notes: every answer has bit 15 clear, so the out bit cleared low by deselect serves as the first answer bit
`timescale 1ns/10ps
`default_nettype none
module scd_shift (
  // link pins
  input  wire logic spi_clk,
  input  wire logic rst_b,
  input  wire logic chip_select_low,
  input  wire logic spi_data_in,
  output logic      spi_data_out,
  // core side
  scd_link_if.link  lnk
);
  import scd_pkg::*;
  `include "scd_defs.svh"

  typedef struct packed {
    logic [15:0] word;
    logic [4:0]  cnt;
    logic        seq;
  } scd_shift_st_t;

  scd_shift_st_t cur;
  scd_shift_st_t next_cur;
  logic          fresh;
  logic          next_so;
  logic          so;

  // fresh marks the first edge of a frame; armed by deselect so no edge is needed after the frame
  always_ff @(posedge spi_clk or posedge chip_select_low) begin
    if (chip_select_low) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  always_comb begin
    next_cur = cur;
    if (fresh) begin
      next_cur.word = {15'h0000, spi_data_in};
      next_cur.cnt  = 5'd1;
      next_cur.seq  = ~cur.seq;
    end else begin
      next_cur.word = {cur.word[14:0], spi_data_in};
      if (cur.cnt != `SCD_CNT_SAT) begin
        next_cur.cnt = cur.cnt + 5'd1;
      end
    end
    next_so = 1'b0;
    if (cur.cnt < `SCD_FRAME_BITS) begin
      next_so = lnk.resp_word[4'(5'd15 - cur.cnt)];
    end
  end

  always_ff @(posedge spi_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // answer bits change on the falling edge
  always_ff @(negedge spi_clk or posedge chip_select_low) begin
    if (chip_select_low) begin
      so <= 1'b0;
    end else begin
      so <= next_so;
    end
  end

  assign spi_data_out = so;
  assign lnk.rx_word  = cur.word;
  assign lnk.bit_cnt  = cur.cnt;
  assign lnk.rx_seq   = cur.seq;
endmodule
`default_nettype wire

// File: dv/scd_host_model.sv
// Purpose: host master model that sends command frames over the serial link
// Assumes: the caller's gap covers the decoder's execute latency after chip select rises
// Notes: the serial clock stands low outside frames; the released data line shows the
//        inverse of its last bit so a stale value cannot pass for a live one
`timescale 1ns/10ps
`default_nettype none
module scd_host_model (
  // link pins
  output logic      spi_clk,
  output logic      chip_select_low,
  output logic      spi_data_in,
  input  wire logic spi_data_out,
  input  wire logic spi_data_oe
);
  logic [15:0] rx_word;
  int          nbits;
  event        got;

  initial begin
    spi_clk = 1'b0;
    chip_select_low = 1'b1;
    spi_data_in = 1'b1;
  end

  // a disabled out driver is taken as unknown, so the watcher flags it
  task automatic xfer(input logic [15:0] w, input int n, input int gap);
    rx_word = 16'h0000;
    nbits = n;
    // a frame, even one with no clocks, stays selected long enough for the core to see it
    #15 chip_select_low = 1'b0;
    for (int i = 0; i < n; i++) begin
      spi_data_in = w[15-i];
      #15 spi_clk = 1'b1;
      rx_word = {rx_word[14:0], spi_data_oe ? spi_data_out : 1'bx};
      #15 spi_clk = 1'b0;
    end
    #15 chip_select_low = 1'b1;
    spi_data_in = ~spi_data_in;
    -> got;
    #(gap);
  endtask
endmodule
`default_nettype wire

// File: dv/scd_cmd_decoder_tb.sv
// Purpose: self-checking bench for the serial command decoder
// Assumes: the host model drives the link; fault inputs and reset move at the falling clock
// Notes: each frame's answer is noted by the sender and checked when the next frame ends
`timescale 1ns/10ps
`default_nettype none
`include "scd_defs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR %0t: got %h exp %h", $time, (a), (e)); end end
module scd_cmd_decoder_tb;
  import scd_pkg::*;
  logic         clock = 1'b0;
  logic         rst_b = 1'b1;
  logic         spi_clk;
  logic         chip_select_low;
  logic         spi_data_in;
  logic         spi_data_out;
  logic         spi_data_oe;
  scd_reg_set_t status_fault_set = '0;
  scd_reg_set_t config_regs;
  scd_reg_set_t control_regs;
  scd_reg_set_t status_regs;
  scd_reg_set_t snap;
  logic         self_test_write_unlock;
  logic [15:0]  exp_q[$];
  int           n_errors = 0;
  int           cmp_count = 0;
  logic [3:0]   a;
  logic [7:0]   d;
  logic [7:0]   m;
  scd_cmd_t     wr_c [3] = '{SCD_CMD_WR_CFG, SCD_CMD_WR_CTL, SCD_CMD_WR_STS};
  scd_cmd_t     rd_c [3] = '{SCD_CMD_RD_CFG, SCD_CMD_RD_CTL, SCD_CMD_RD_STS};
  logic [15:0]  bad_w [6] = '{16'h2e55, 16'h2e55, 16'h8123, 16'hf0aa, 16'h21ff, 16'h29ff};
  int           bad_n [6] = '{15, 0, 16, 16, 16, 16};

  always #2 clock = ~clock;

  scd_cmd_decoder scd_cmd_decoder_i (
    .clock, .rst_b, .spi_clk, .chip_select_low, .spi_data_in, .spi_data_out, .spi_data_oe,
    .status_fault_set, .config_regs, .control_regs, .status_regs, .self_test_write_unlock);

  scd_host_model scd_host_model_i (
    .spi_clk, .chip_select_low, .spi_data_in, .spi_data_out, .spi_data_oe);

  // a short frame only carries the top bits of the pending answer
  always @(scd_host_model_i.got) begin
    logic [31:0] e;
    e = {16'h0000, exp_q.pop_front()} >> (16 - scd_host_model_i.nbits);
    `CHK(scd_host_model_i.rx_word, e[15:0])
  end

  task automatic send(input logic [15:0] w, input int n, input logic [15:0] ans);
    exp_q.push_back(ans);
    scd_host_model_i.xfer(w, n, 30 + $urandom % 90);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    end_sim();
  end

  initial begin
    void'($urandom(81));
    // a real falling edge, so the shifter's asynchronous clear fires
    rst_b = 1'b0;
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    repeat (3) @(negedge clock);
    exp_q.push_back(16'h0000);
    `CHK(config_regs, `SCD_CFG_RESET)
    `CHK(control_regs, `SCD_CTL_RESET)
    `CHK(status_regs, `SCD_STS_RESET)
    `CHK(spi_data_oe, 1'b0)
    $display("test reset done");

    for (int i = 0; i < 3; i++) begin
      a = $urandom;
      d = $urandom;
      send({SCD_CMD_CHECK, a, d}, 16, {SCD_CMD_RESP, a, d});
    end
    $display("test link check done");

    send({SCD_CMD_WR_CTL, 4'hf, 8'h80}, 16, 16'h0000);
    `CHK(self_test_write_unlock, 1'b1)
    @(negedge clock);
    // faults must be ignored while unlocked
    status_fault_set = {$urandom, $urandom, $urandom, $urandom};
    for (int k = 0; k < 3; k++) begin
      a = $urandom;
      // config 1 and 9 are refused, control 15 holds the unlock
      if (k == 0 && a[2:0] == 3'h1) a = 4'h2;
      if (k == 1) a[3] = 1'b0;
      d = $urandom;
      send({wr_c[k], a, d}, 16, 16'h0000);
      snap = k == 0 ? config_regs : k == 1 ? control_regs : status_regs;
      `CHK(snap[a], d)
      send({rd_c[k], a, 8'h00}, 16, {rd_c[k], a, d});
    end
    $display("test write read done");

    @(negedge clock);
    status_fault_set = '0;
    send({SCD_CMD_WR_CTL, 4'hf, 8'h00}, 16, 16'h0000);
    `CHK(self_test_write_unlock, 1'b0)
    m = $urandom;
    send({SCD_CMD_WR_STS, a, m}, 16, 16'h0000);
    `CHK(status_regs[a], d & m)
    @(negedge clock);
    status_fault_set[2][0] = 1'b1;
    @(negedge clock);
    status_fault_set[2][0] = 1'b0;
    repeat (2) @(negedge clock);
    `CHK(status_regs[2][0], 1'b1)
    $display("test status clear done");

    snap = config_regs;
    for (int k = 0; k < 6; k++) begin
      send(bad_w[k], bad_n[k], 16'h0000);
      `CHK(status_regs[`SCD_FAULT_REG][`SCD_COMM_ERR_BIT], 1'b1)
      `CHK(config_regs, snap)
      send({SCD_CMD_WR_STS, `SCD_FAULT_REG, 8'h00}, 16, 16'h0000);
      `CHK(status_regs[`SCD_FAULT_REG], 8'h00)
    end
    send({SCD_CMD_CHECK, 12'h5a5}, 16, {SCD_CMD_RESP, 12'h5a5});
    send({SCD_CMD_CHECK, 12'ha5a}, 16, {SCD_CMD_RESP, 12'ha5a});
    $display("test frame errors done");
    end_sim();
  end
endmodule
`default_nettype wire
